/* dv/nfc_config_request_handler_tb_top.sv */
/*
  Testbench of the NFC request handler: page tasks and request sequences.
  Assumes the writer model and the port checker beside it.
*/
`timescale 1ns/1ps

module nfc_config_request_handler_tb_top;
  // --------------------------------------------------------------------------
  // Harness
  // --------------------------------------------------------------------------
  logic mclk;
  logic reset = 1'b1;
  logic [15:0] page_addr;
  logic page_write, page_read, page_rvalid;
  logic [31:0] page_wdata, page_rdata, d;
  logic press, release_pin, learn;
  logic send_comm, send_decomm, config_zgp, pending;
  int n_errors = 0;
  int checks = 0;
  int n_comm = 0;
  int n_decomm = 0;
  bit ok;

  nfcrh_request_handler uut (.MCLK(mclk), .RESET(reset), .PAGE_ADDR(page_addr), .PAGE_WRITE(page_write),
    .PAGE_WDATA(page_wdata), .PAGE_READ(page_read), .PAGE_RDATA(page_rdata), .PAGE_RVALID(page_rvalid),
    .HARVEST_PRESS(press), .HARVEST_RELEASE(release_pin), .LEARN_BUTTON(learn),
    .SEND_COMMISSION(send_comm), .SEND_DECOMMISSION(send_decomm), .CONFIG_ZGP(config_zgp),
    .REQUEST_PENDING(pending));

  nfcrh_writer writer (.mclk(mclk), .page_addr(page_addr), .page_write(page_write), .page_wdata(page_wdata),
    .page_read(page_read), .page_rdata(page_rdata), .page_rvalid(page_rvalid), .harvest_press(press),
    .harvest_release(release_pin), .learn_button(learn));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (send_comm === 1'b1) n_comm++;
    if (send_decomm === 1'b1) n_decomm++;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic page(input logic [15:0] a, input logic [31:0] exp, input string what);
    writer.rd(a, d, ok);
    if (!ok) begin
      n_errors++;
      tally_and_finish();
    end else begin
      chk32(what, exp, d);
    end
  endtask

  task automatic req(input logic [31:0] r, input logic [31:0] pin);
    writer.wr(16'h0050, r);
    writer.wr(16'h0052, pin);
  endtask

  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    page(16'h004d, 32'h00000000, "outcome at reset");
    page(16'h0061, 32'h0000000f, "permits at reset");
    // Selection written but request is not an update
    req(32'h12000000, 32'h02000000);
    writer.wr(16'h0054, 32'h00000001);
    writer.wr(16'h0058, 32'h00000001);
    page(16'h004d, 32'h00000000, "outcome before actuation");
    chk1("pending", 1'b1, pending);
    writer.act(1, 0);
    page(16'h004d, 32'h52000000, "commission progress");
    writer.act(0, 1);
    page(16'h004d, 32'h32000000, "commission done");
    chk1("mode after commission", 1'b0, config_zgp);
    chk32("commission count", 32'h1, n_comm);
    req(32'h12000000, 32'h02000001);
    writer.act(1, 1);
    page(16'h004d, 32'h72000000, "primary pin error");
    chk32("commission count", 32'h1, n_comm);
    req(32'h14000000, 32'h02000000);
    writer.act(1, 0);
    page(16'h004d, 32'hb4000000, "decommission in ble");
    chk1("pending after error", 1'b0, pending);
    // Update words 0 and 1, word 2 staged but not selected
    req(32'h11000000, 32'h02000000);
    writer.wr(16'h0054, 32'h00000003);
    writer.wr(16'h0058, 32'h00000001);
    writer.wr(16'h0059, 32'h00000000);
    writer.wr(16'h005a, 32'h00123456);
    writer.act(5, 4);
    page(16'h004d, 32'h51000000, "update progress");
    writer.act(0, 1);
    page(16'h004d, 32'h31000000, "update done");
    chk1("mode after update", 1'b1, config_zgp);
    writer.pulse(2);
    chk32("learn in zgp count", 32'h2, n_comm);
    page(16'h0061, 32'h00000000, "permits after update");
    req(32'h1a000000, 32'h03000001);
    writer.act(1, 0);
    page(16'h004d, 32'h7a000000, "secondary pin error");
    req(32'h1a000000, 32'h03000000);
    writer.act(1, 0);
    page(16'h004d, 32'h9a000000, "secondary not permitted");
    chk32("commission count", 32'h2, n_comm);
    req(32'h14000000, 32'h02000000);
    writer.act(1, 1);
    page(16'h004d, 32'h34000000, "decommission in zgp");
    chk32("decommission count", 32'h1, n_decomm);
    req(32'h13000000, 32'h02000000);
    writer.act(5, 5);
    page(16'h004d, 32'h33000000, "factory reset done");
    chk1("mode after factory reset", 1'b0, config_zgp);
    page(16'h0061, 32'h0000000f, "permits after factory reset");
    req(32'h1a000000, 32'h03000000);
    writer.act(1, 1);
    page(16'h004d, 32'h3a000000, "secondary commission");
    chk32("commission count", 32'h3, n_comm);
    writer.pulse(2);
    chk32("learn commission count", 32'h4, n_comm);
    tally_and_finish();
  end
endmodule

bind nfcrh_request_handler nfcrh_sva sva_i (.MCLK(MCLK), .RESET(RESET), .PAGE_ADDR(PAGE_ADDR),
  .PAGE_WRITE(PAGE_WRITE), .PAGE_READ(PAGE_READ), .PAGE_RDATA(PAGE_RDATA), .PAGE_RVALID(PAGE_RVALID),
  .SEND_COMMISSION(SEND_COMMISSION), .SEND_DECOMMISSION(SEND_DECOMMISSION), .CONFIG_ZGP(CONFIG_ZGP),
  .REQUEST_PENDING(REQUEST_PENDING));

/* dv/nfcrh_sva.sv */
/*
  Port checker of the NFC request handler.
  Assumes a bind onto nfcrh_request_handler, one clock domain.
*/
`timescale 1ns/1ps

module nfcrh_sva (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [15:0] PAGE_ADDR,
  input wire logic PAGE_WRITE,
  input wire logic PAGE_READ,
  input wire logic [31:0] PAGE_RDATA,
  input wire logic PAGE_RVALID,
  input wire logic SEND_COMMISSION,
  input wire logic SEND_DECOMMISSION,
  input wire logic CONFIG_ZGP,
  input wire logic REQUEST_PENDING
);
  // --------------------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  sequence s_req_write;
    PAGE_WRITE && PAGE_ADDR == 16'h0050;
  endsequence

  sequence s_outcome_read;
    PAGE_READ && PAGE_ADDR == 16'h004d;
  endsequence

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_read_answered: assert property (PAGE_READ |=> PAGE_RVALID)
    else $error("read not answered next cycle");
  a_no_stray_valid: assert property (!PAGE_READ |=> !PAGE_RVALID)
    else $error("read valid without read");
  a_outcome_byte0: assert property (s_outcome_read |=> PAGE_RDATA[23:0] == 24'h000000)
    else $error("outcome page low bytes not zero");
  a_request_arms: assert property (s_req_write |-> ##2 REQUEST_PENDING)
    else $error("request write did not arm");
  a_pending_cause: assert property ($rose(REQUEST_PENDING) |-> $past(PAGE_WRITE && PAGE_ADDR == 16'h0050, 2))
    else $error("pending rose without request write");
  a_decomm_zgp: assert property (SEND_DECOMMISSION |-> CONFIG_ZGP)
    else $error("decommission sent in other mode");
  a_decomm_cause: assert property (SEND_DECOMMISSION |-> $past(REQUEST_PENDING, 2))
    else $error("decommission sent without request");
  a_commission_pulse: assert property (SEND_COMMISSION |=> !SEND_COMMISSION)
    else $error("commission pulse too long");
  a_config_cause: assert property ($changed(CONFIG_ZGP) |-> $past(REQUEST_PENDING))
    else $error("mode changed without request");
endmodule

/* dv/nfcrh_writer.sv */
/*
  Model of the NFC writer and of the harvester and learn pins.
  Assumes the page bus of the handler on the same clock.
*/
`timescale 1ns/1ps

module nfcrh_writer (
  input wire logic mclk,
  output logic [15:0] page_addr,
  output logic page_write,
  output logic [31:0] page_wdata,
  output logic page_read,
  input wire logic [31:0] page_rdata,
  input wire logic page_rvalid,
  output logic harvest_press,
  output logic harvest_release,
  output logic learn_button
);
  // --------------------------------------------------------------------------
  // Page accesses and pins
  // --------------------------------------------------------------------------
  logic [2:0] pins = 3'h0;

  assign harvest_press = pins[0];
  assign harvest_release = pins[1];
  assign learn_button = pins[2];

  initial begin
    page_addr = 16'h0000;
    page_write = 1'b0;
    page_wdata = 32'h00000000;
    page_read = 1'b0;
  end

  // Whole page, byte 0 in the top byte; bus scrambled when idle
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    page_addr = a;
    page_wdata = d;
    page_write = 1'b1;
    @(negedge mclk);
    page_write = 1'b0;
    page_addr = ~a;
    page_wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output bit ok);
    ok = 1'b0;
    d = 32'h00000000;
    @(negedge mclk);
    page_addr = a;
    page_read = 1'b1;
    @(negedge mclk);
    page_read = 1'b0;
    page_addr = ~a;
    for (int i = 0; i < 4; i++) begin
      if (page_rvalid === 1'b1) begin
        ok = 1'b1;
        d = page_rdata;
        break;
      end
      @(negedge mclk);
    end
  endtask

  task automatic pulse(input int k);
    @(negedge mclk);
    pins[k] = 1'b1;
    repeat (8) @(negedge mclk);
    pins[k] = 1'b0;
    repeat (8) @(negedge mclk);
  endtask

  task automatic act(input int p, input int r);
    repeat (p) pulse(0);
    repeat (r) pulse(1);
  endtask
endmodule

/* hw/nfcrh_params.svh */
/*
  Page offsets, field positions, codes, reset values and actuation counts
  of the NFC request handler. Assumes inclusion by bare name.
*/
`ifndef NFCRH_PARAMS_SVH
`define NFCRH_PARAMS_SVH

// ----------------------------------------------------------------------------
// Page addresses
// ----------------------------------------------------------------------------
`define NFCRH_PAGE_OUTCOME 16'h004d
`define NFCRH_PAGE_REQUEST 16'h0050
`define NFCRH_PAGE_PIN 16'h0052
`define NFCRH_PAGE_SELECT 16'h0054
`define NFCRH_PAGE_STAGED 16'h0058
`define NFCRH_PAGE_ACTIVE 16'h0060
`define NFCRH_CFG_WORDS 4

// ----------------------------------------------------------------------------
// Request byte fields
// ----------------------------------------------------------------------------
`define NFCRH_REQ_CLASS 4'h1
`define NFCRH_REQ_USER_BIT 3
`define NFCRH_FN_UPDATE 3'h1
`define NFCRH_FN_COMMISSION 3'h2
`define NFCRH_FN_RESET 3'h3
`define NFCRH_FN_DECOMMISSION 3'h4
`define NFCRH_PIN_LEAD_PRIMARY 8'h02
`define NFCRH_PIN_LEAD_SECONDARY 8'h03

// ----------------------------------------------------------------------------
// Configuration word layout and reset values
// ----------------------------------------------------------------------------
`define NFCRH_CFG_MODE 0
`define NFCRH_CFG_PERMIT 1
`define NFCRH_CFG_PRIMARY_CODE 2
`define NFCRH_CFG_SECONDARY_CODE 3
`define NFCRH_MODE_ZGP_BIT 0
`define NFCRH_CFG0_RESET 32'h0000_0000
`define NFCRH_CFG1_RESET 32'h0000_000f
`define NFCRH_CFG2_RESET 32'h0000_0000
`define NFCRH_CFG3_RESET 32'h0000_0000
`define NFCRH_OUTCOME_RESET 8'h00

// ----------------------------------------------------------------------------
// Actuations needed per direction
// ----------------------------------------------------------------------------
`define NFCRH_ENERGY_CONFIG 3'h5
`define NFCRH_ENERGY_TELEGRAM 3'h1

`endif

/* hw/nfcrh_pin_sync.sv */
/*
  Three-stage synchroniser with rising-edge pulse for asynchronous pins.
  Assumes pins are plain levels from outside the MCLK domain.
*/
`timescale 1ns/1ps

module nfcrh_pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // --------------------------------------------------------------------------
  // Per-pin chain, accepted once stages two and three agree
  // --------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          level[i] <= 1'b0;
          rise[i] <= 1'b0;
        end else begin
          stage1[i] <= pin[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          rise[i] <= 1'b0;
          if (stage2[i] == stage3[i]) begin
            level[i] <= stage3[i];
            rise[i] <= stage3[i] & ~level[i];
          end
        end
      end
    end
  endgenerate

endmodule

/* hw/nfcrh_pkg.sv */
/*
  Types of the NFC request handler.
  Assumes nothing of its surroundings.
*/
package nfcrh_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PENDING = 1'b1
  } nfcrh_state_t;

  typedef enum logic [2:0] {
    OUT_SUCCESS = 3'b001,
    OUT_PROGRESS = 3'b010,
    OUT_PIN_ERROR = 3'b011,
    OUT_PERMIT_ERROR = 3'b100,
    OUT_PARAM_ERROR = 3'b101
  } nfcrh_status_t;

endpackage

/* hw/nfcrh_request_handler.sv */
/*
  NFC request handler: takes request, PIN, selection and staged pages
  written by an NFC writer, and runs the request on harvester actuations.
  Assumes a page front end on MCLK delivering whole four-byte pages,
  byte 0 in bits 31:24, and harvester and learn pins from outside.
*/
// Contract
// - Unselected staged words leave config unchanged
// - Selection applies only to register-update requests
// - Outcome byte sits in byte 0 of page
// - Primary commissioning request is 0x12 000000
// - Secondary commissioning request is 0x1A 000000
// - Primary PIN page leads with 0x02
// - Secondary PIN page leads with 0x03
// - Request runs at next harvester actuation
// - Primary commissioning codes 0x32, 0x52, 0x72
// - Secondary codes 0x3A, 0x5A, 0x7A, 0x9A
// - In progress until enough actuations accumulate
// - Learn button sends commissioning in both modes
// - Decommissioning accepted only in ZGP mode
// - Commission, decommission and factory reset supported
// - Pages move four bytes, byte 0 first
// - Decommission 0x14 answers 0xB4 in BLE mode
`timescale 1ns/1ps
`include "nfcrh_params.svh"

module nfcrh_request_handler #(
  parameter int CFG_WORDS = `NFCRH_CFG_WORDS,
  parameter logic [2:0] ENERGY_CONFIG = `NFCRH_ENERGY_CONFIG,
  parameter logic [2:0] ENERGY_TELEGRAM = `NFCRH_ENERGY_TELEGRAM
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [15:0] PAGE_ADDR,
  input wire logic PAGE_WRITE,
  input wire logic [31:0] PAGE_WDATA,
  input wire logic PAGE_READ,
  output logic [31:0] PAGE_RDATA,
  output logic PAGE_RVALID,
  input wire logic HARVEST_PRESS,
  input wire logic HARVEST_RELEASE,
  input wire logic LEARN_BUTTON,
  output logic SEND_COMMISSION,
  output logic SEND_DECOMMISSION,
  output logic CONFIG_ZGP,
  output logic REQUEST_PENDING
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  nfcrh_pkg::nfcrh_state_t state;
  logic [31:0] request_type_originator;
  logic [31:0] request_pin;
  logic [31:0] update_selection;
  logic [31:0] staged [CFG_WORDS];
  logic [31:0] active [CFG_WORDS];
  logic [7:0] request_outcome;
  logic [2:0] press_count;
  logic [2:0] release_count;
  logic [2:0] pin_level;
  logic [2:0] pin_rise;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  nfcrh_pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(MCLK),
    .rst(RESET),
    .pin({LEARN_BUTTON, HARVEST_RELEASE, HARVEST_PRESS}),
    .level(pin_level),
    .rise(pin_rise)
  );

  logic press_evt;
  logic release_evt;
  logic learn_evt;
  logic act_evt;
  assign press_evt = pin_rise[0];
  assign release_evt = pin_rise[1];
  assign learn_evt = pin_rise[2];
  assign act_evt = press_evt | release_evt;

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] outcome_byte(input nfcrh_pkg::nfcrh_status_t st, input logic [7:0] req);
    outcome_byte = {st, req[4:0]};
  endfunction

  function automatic logic page_hit(input logic [15:0] addr, input logic [15:0] base, input int idx);
    page_hit = (addr == base + 16'(idx));
  endfunction

  function automatic logic [31:0] cfg_reset(input int idx);
    case (idx)
      0: cfg_reset = `NFCRH_CFG0_RESET;
      1: cfg_reset = `NFCRH_CFG1_RESET;
      2: cfg_reset = `NFCRH_CFG2_RESET;
      3: cfg_reset = `NFCRH_CFG3_RESET;
      default: cfg_reset = 32'h0000_0000;
    endcase
  endfunction

  logic wr_request;
  logic wr_pin;
  logic wr_select;
  assign wr_request = PAGE_WRITE && page_hit(PAGE_ADDR, `NFCRH_PAGE_REQUEST, 0);
  assign wr_pin = PAGE_WRITE && page_hit(PAGE_ADDR, `NFCRH_PAGE_PIN, 0);
  assign wr_select = PAGE_WRITE && page_hit(PAGE_ADDR, `NFCRH_PAGE_SELECT, 0);

  // --------------------------------------------------------------------------
  // Request evaluation
  // --------------------------------------------------------------------------
  logic [7:0] req_byte;
  logic [2:0] req_fn;
  logic req_secondary;
  logic kind_ok;
  logic pin_ok;
  logic permit_ok;
  logic param_ok;
  logic [2:0] next_press;
  logic [2:0] next_release;
  logic [2:0] need;
  logic energy_ok;
  logic fails;
  logic execute;
  nfcrh_pkg::nfcrh_status_t status;

  assign req_byte = request_type_originator[31:24];
  assign req_fn = req_byte[2:0];
  assign req_secondary = req_byte[`NFCRH_REQ_USER_BIT];
  assign kind_ok = (req_byte[7:4] == `NFCRH_REQ_CLASS) && (req_fn >= `NFCRH_FN_UPDATE)
    && (req_fn <= `NFCRH_FN_DECOMMISSION) && (request_type_originator[23:0] == 24'h000000);

  always_comb begin
    if (req_secondary) begin
      pin_ok = (request_pin[31:24] == `NFCRH_PIN_LEAD_SECONDARY)
        && (request_pin[23:0] == active[`NFCRH_CFG_SECONDARY_CODE][23:0]);
    end else begin
      pin_ok = (request_pin[31:24] == `NFCRH_PIN_LEAD_PRIMARY)
        && (request_pin[23:0] == active[`NFCRH_CFG_PRIMARY_CODE][23:0]);
    end
  end

  always_comb begin
    if (!req_secondary || !kind_ok) begin
      permit_ok = 1'b1;
    end else begin
      permit_ok = active[`NFCRH_CFG_PERMIT][req_fn - 3'h1];
    end
  end

  assign param_ok = kind_ok && ((req_fn != `NFCRH_FN_DECOMMISSION)
    || active[`NFCRH_CFG_MODE][`NFCRH_MODE_ZGP_BIT]);

  assign next_press = (press_evt && press_count != 3'h7) ? press_count + 3'h1 : press_count;
  assign next_release = (release_evt && release_count != 3'h7) ? release_count + 3'h1 : release_count;
  assign need = (req_fn == `NFCRH_FN_UPDATE || req_fn == `NFCRH_FN_RESET) ? ENERGY_CONFIG : ENERGY_TELEGRAM;
  assign energy_ok = (next_press >= need) && (next_release >= need);

  always_comb begin
    if (!pin_ok) begin
      status = nfcrh_pkg::OUT_PIN_ERROR;
    end else if (!permit_ok) begin
      status = nfcrh_pkg::OUT_PERMIT_ERROR;
    end else if (!param_ok) begin
      status = nfcrh_pkg::OUT_PARAM_ERROR;
    end else if (!energy_ok) begin
      status = nfcrh_pkg::OUT_PROGRESS;
    end else begin
      status = nfcrh_pkg::OUT_SUCCESS;
    end
  end

  assign fails = !pin_ok || !permit_ok || !param_ok;
  assign execute = (state == nfcrh_pkg::ST_PENDING) && act_evt && !fails && energy_ok && !wr_request;

  // --------------------------------------------------------------------------
  // Pending request state
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state <= nfcrh_pkg::ST_IDLE;
    end else begin
      case (state)
        nfcrh_pkg::ST_IDLE: begin
          if (wr_request) begin
            state <= nfcrh_pkg::ST_PENDING;
          end
        end
        nfcrh_pkg::ST_PENDING: begin
          if (!wr_request && act_evt && (fails || energy_ok)) begin
            state <= nfcrh_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= nfcrh_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Writable pages
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      request_type_originator <= 32'h0000_0000;
      request_pin <= 32'h0000_0000;
      update_selection <= 32'h0000_0000;
    end else begin
      if (wr_request) begin
        request_type_originator <= PAGE_WDATA;
      end
      if (wr_pin) begin
        request_pin <= PAGE_WDATA;
      end
      if (wr_select) begin
        update_selection <= PAGE_WDATA;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CFG_WORDS; gi = gi + 1) begin : g_cfg
      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          staged[gi] <= 32'h0000_0000;
        end else if (PAGE_WRITE && page_hit(PAGE_ADDR, `NFCRH_PAGE_STAGED, gi)) begin
          staged[gi] <= PAGE_WDATA;
        end
      end

      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          active[gi] <= cfg_reset(gi);
        end else if (execute && req_fn == `NFCRH_FN_RESET) begin
          active[gi] <= cfg_reset(gi);
        end else if (execute && req_fn == `NFCRH_FN_UPDATE && update_selection[gi]) begin
          active[gi] <= staged[gi];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Actuation counters, cleared by each new request
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      press_count <= 3'h0;
      release_count <= 3'h0;
    end else if (wr_request) begin
      press_count <= 3'h0;
      release_count <= 3'h0;
    end else if (state == nfcrh_pkg::ST_PENDING) begin
      press_count <= next_press;
      release_count <= next_release;
    end
  end

  // --------------------------------------------------------------------------
  // Outcome page
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      request_outcome <= `NFCRH_OUTCOME_RESET;
    end else if (state == nfcrh_pkg::ST_PENDING && act_evt && !wr_request) begin
      request_outcome <= outcome_byte(status, req_byte);
    end
  end

  // --------------------------------------------------------------------------
  // Telegram requests and status outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      SEND_COMMISSION <= 1'b0;
      SEND_DECOMMISSION <= 1'b0;
    end else begin
      SEND_COMMISSION <= learn_evt || (execute && req_fn == `NFCRH_FN_COMMISSION);
      SEND_DECOMMISSION <= execute && req_fn == `NFCRH_FN_DECOMMISSION;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      CONFIG_ZGP <= 1'b0;
      REQUEST_PENDING <= 1'b0;
    end else begin
      CONFIG_ZGP <= active[`NFCRH_CFG_MODE][`NFCRH_MODE_ZGP_BIT];
      REQUEST_PENDING <= (state == nfcrh_pkg::ST_PENDING);
    end
  end

  // --------------------------------------------------------------------------
  // Page reads, answered one cycle later
  // --------------------------------------------------------------------------
  logic [31:0] read_word;

  always_comb begin
    read_word = 32'h0000_0000;
    if (page_hit(PAGE_ADDR, `NFCRH_PAGE_OUTCOME, 0)) begin
      read_word = {request_outcome, 24'h000000};
    end else if (page_hit(PAGE_ADDR, `NFCRH_PAGE_REQUEST, 0)) begin
      read_word = request_type_originator;
    end else if (page_hit(PAGE_ADDR, `NFCRH_PAGE_SELECT, 0)) begin
      read_word = update_selection;
    end
    for (int k = 0; k < CFG_WORDS; k++) begin
      if (page_hit(PAGE_ADDR, `NFCRH_PAGE_STAGED, k)) begin
        read_word = staged[k];
      end
      if (page_hit(PAGE_ADDR, `NFCRH_PAGE_ACTIVE, k)
          && k != `NFCRH_CFG_PRIMARY_CODE && k != `NFCRH_CFG_SECONDARY_CODE) begin
        read_word = active[k];
      end
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      PAGE_RDATA <= 32'h0000_0000;
      PAGE_RVALID <= 1'b0;
    end else begin
      PAGE_RVALID <= PAGE_READ;
      if (PAGE_READ) begin
        PAGE_RDATA <= read_word;
      end
    end
  end

endmodule
